// ===== verilog/pcx_top.sv
/*
 * PWM cycle configuration, reload banking, cycle overflow flag,
 * comparator clear and channel mode registers of a three channel
 * counter array.
 * Assumes the counter value and its tick come from logic on clk, the
 * comparator result is asynchronous, and the CPU core drives the
 * register bus synchronously.
 */
`timescale 1ns/100ps
`include "pcx_cfg.svh"

module pcx_top (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              arst_n,
    // Register bus
    input  wire pcx_pkg::pcx_byte_t sfr_addr,
    input  wire logic              sfr_wr,
    input  wire logic              sfr_rd,
    input  wire pcx_pkg::pcx_byte_t sfr_wdata,
    output pcx_pkg::pcx_byte_t     sfr_rdata,
    output logic                   sfr_rvalid,
    // Counter timebase
    input  wire pcx_pkg::pcx_word_t main_array_counter,
    input  wire logic              cnt_tick,
    // Comparator
    input  wire logic              cmp_result_in,
    // Outputs
    output logic                   pca_irq_req,
    output logic                   channel_out_0,
    output logic                   channel_out_1,
    output logic                   channel_out_2
);
    import pcx_pkg::*;

    localparam int NCH = 3;
    localparam logic [NCH-1:0][7:0] LO_ADDR =
        {`PCX_ADDR_CMP2_LO, `PCX_ADDR_CMP1_LO, `PCX_ADDR_CMP0_LO};
    localparam logic [NCH-1:0][7:0] HI_ADDR =
        {`PCX_ADDR_CMP2_HI, `PCX_ADDR_CMP1_HI, `PCX_ADDR_CMP0_HI};
    localparam logic [NCH-1:0][7:0] MODE_ADDR =
        {`PCX_ADDR_MODE2, `PCX_ADDR_MODE1, `PCX_ADDR_MODE0};

    typedef struct packed {
        pcx_pwm_cfg_t             pwm;
        pcx_clr_t                 clr;
        pcx_mode_t [NCH-1:0]      mode;
        pcx_word_t [NCH-1:0]      cmp;
        pcx_word_t [NCH-1:0]      arl;
        logic                     sync1;
        logic                     sync2;
        logic                     cmp_prev;
        logic                     sync_warm1;
        logic                     sync_warm2;
        logic                     sync_warm3;
        pcx_byte_t                rdata;
        logic                     rvalid;
    } pcx_state_t;

    pcx_state_t     st_r;
    pcx_state_t     st_nxt;
    pcx_word_t      len_mask;
    logic           wrap_short;
    logic           wrap_wide;
    logic           cmp_edge;
    logic [NCH-1:0] clear_en;
    logic [NCH-1:0] clear_evt;
    logic [NCH-1:0] ch_out;
    pcx_pwm_cfg_t   wr_pwm;
    pcx_clr_t       wr_clr;

    // ******************************************************************
    // Cycle timing and comparator events
    // ******************************************************************
    assign len_mask   = pcx_len_mask(st_r.pwm.cycle_length_select);
    assign wrap_short = cnt_tick &&
        ((main_array_counter & len_mask) == len_mask);
    assign wrap_wide  = cnt_tick && (main_array_counter == `PCX_MASK_16);
    // No edge until synchroniser and history hold real pin samples
    assign cmp_edge   = st_r.sync_warm3 && (st_r.clr.cmp_clear_polarity ?
        (st_r.sync2 && !st_r.cmp_prev) :
        (!st_r.sync2 && st_r.cmp_prev));
    assign clear_en   = {st_r.clr.cmp_clear_enable_ch2,
                         st_r.clr.cmp_clear_enable_ch1,
                         st_r.clr.cmp_clear_enable_ch0};
    assign clear_evt  = clear_en & {NCH{cmp_edge}};
    assign wr_pwm     = pcx_pwm_cfg_t'(sfr_wdata);
    assign wr_clr     = pcx_clr_t'(sfr_wdata);

    // ******************************************************************
    // Register file
    // ******************************************************************
    always_comb begin
        st_nxt        = st_r;
        st_nxt.rvalid = 1'b0;
        st_nxt.sync1  = cmp_result_in;
        st_nxt.sync2  = st_r.sync1;
        st_nxt.cmp_prev = st_r.sync2;
        st_nxt.sync_warm1 = 1'b1;
        st_nxt.sync_warm2 = st_r.sync_warm1;
        st_nxt.sync_warm3 = st_r.sync_warm2;
        if (sfr_wr && sfr_addr == `PCX_ADDR_PWM_CFG) begin
            st_nxt.pwm      = wr_pwm;
            st_nxt.pwm.rsvd = '0;
        end
        if (sfr_wr && sfr_addr == `PCX_ADDR_CLR_CTRL) begin
            st_nxt.clr      = wr_clr;
            st_nxt.clr.rsvd = '0;
        end
        for (int i = 0; i < NCH; i++) begin
            if (sfr_wr && sfr_addr == MODE_ADDR[i]) begin
                st_nxt.mode[i] = pcx_mode_t'(sfr_wdata);
            end
            if (sfr_wr && sfr_addr == LO_ADDR[i]) begin
                if (st_r.pwm.reload_bank_select) begin
                    st_nxt.arl[i][7:0] = sfr_wdata;
                end else begin
                    st_nxt.cmp[i][7:0] = sfr_wdata;
                end
            end
            if (sfr_wr && sfr_addr == HI_ADDR[i]) begin
                if (st_r.pwm.reload_bank_select) begin
                    st_nxt.arl[i][15:8] = sfr_wdata;
                end else begin
                    st_nxt.cmp[i][15:8] = sfr_wdata;
                end
            end
            // Reload bank feeds the compare value only in 9-11 bit PWM
            if (wrap_short && st_r.mode[i].pwm_enable &&
                !st_r.mode[i].wide_pwm_select &&
                pcx_len_ext(st_r.pwm.cycle_length_select)) begin
                st_nxt.cmp[i] = st_r.arl[i];
            end
        end
        // Hardware set wins over a software clear in the same cycle
        if (wrap_short) begin
            st_nxt.pwm.cycle_ovf_flag = 1'b1;
        end
        if (sfr_rd) begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rdata  = `PCX_READ_UNMAPPED;
            if (sfr_addr == `PCX_ADDR_PWM_CFG) begin
                st_nxt.rdata = pcx_byte_t'(st_r.pwm);
            end
            if (sfr_addr == `PCX_ADDR_CLR_CTRL) begin
                st_nxt.rdata = pcx_byte_t'(st_r.clr);
            end
            for (int i = 0; i < NCH; i++) begin
                if (sfr_addr == MODE_ADDR[i]) begin
                    st_nxt.rdata = pcx_byte_t'(st_r.mode[i]);
                end
                if (sfr_addr == LO_ADDR[i]) begin
                    st_nxt.rdata = st_r.pwm.reload_bank_select ?
                        st_r.arl[i][7:0] : st_r.cmp[i][7:0];
                end
                if (sfr_addr == HI_ADDR[i]) begin
                    st_nxt.rdata = st_r.pwm.reload_bank_select ?
                        st_r.arl[i][15:8] : st_r.cmp[i][15:8];
                end
            end
        end
    end

    // All registers, clear control included, reset to zero
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ******************************************************************
    // Channels and outputs
    // ******************************************************************
    for (genvar g = 0; g < NCH; g++) begin : gen_ch
        pcx_channel u_ch (
            .clk        (clk),
            .arst_n     (arst_n),
            .mode       (st_r.mode[g]),
            .cmp_value  (st_r.cmp[g]),
            .len_mask   (len_mask),
            .cnt        (main_array_counter),
            .wrap_short (wrap_short),
            .wrap_wide  (wrap_wide),
            .clear_evt  (clear_evt[g]),
            .ch_out     (ch_out[g])
        );
    end

    assign pca_irq_req = st_r.pwm.cycle_ovf_flag &&
                         st_r.pwm.cycle_ovf_irq_enable;
    assign sfr_rdata     = st_r.rdata;
    assign sfr_rvalid    = st_r.rvalid;
    assign channel_out_0 = ch_out[0];
    assign channel_out_1 = ch_out[1];
    assign channel_out_2 = ch_out[2];

    // ******************************************************************
    // Checks
    // ******************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    property p_bank_read;
        sfr_rd && sfr_addr == `PCX_ADDR_CMP0_LO &&
        st_r.pwm.reload_bank_select |=> sfr_rvalid &&
        sfr_rdata == $past(st_r.arl[0][7:0]);
    endproperty
    a_bank_read: assert property (p_bank_read)
        else $error("reload bank not read at compare address");

    property p_irq_on;
        st_r.pwm.cycle_ovf_flag && st_r.pwm.cycle_ovf_irq_enable
        |-> pca_irq_req;
    endproperty
    a_irq_on: assert property (p_irq_on)
        else $error("enabled overflow flag gave no request");

    property p_irq_off;
        !st_r.pwm.cycle_ovf_irq_enable |-> !pca_irq_req;
    endproperty
    a_irq_off: assert property (p_irq_off)
        else $error("masked overflow flag raised request");

    property p_ovf_set;
        wrap_short |=> st_r.pwm.cycle_ovf_flag;
    endproperty
    a_ovf_set: assert property (p_ovf_set)
        else $error("cycle overflow did not set flag");

    property p_flag_hold;
        st_r.pwm.cycle_ovf_flag &&
        !(sfr_wr && sfr_addr == `PCX_ADDR_PWM_CFG)
        |=> st_r.pwm.cycle_ovf_flag;
    endproperty
    a_flag_hold: assert property (p_flag_hold)
        else $error("overflow flag cleared without software");

    property p_reload;
        wrap_short && st_r.mode[0].pwm_enable &&
        !st_r.mode[0].wide_pwm_select &&
        st_r.pwm.cycle_length_select == `PCX_LEN_10
        |=> st_r.cmp[0] == $past(st_r.arl[0]);
    endproperty
    a_reload: assert property (p_reload)
        else $error("reload value not applied at cycle end");

    property p_no_reload;
        (st_r.mode[0].wide_pwm_select || !st_r.mode[0].pwm_enable) &&
        !sfr_wr |=> $stable(st_r.cmp[0]);
    endproperty
    a_no_reload: assert property (p_no_reload)
        else $error("reload bank touched compare value");

endmodule

// ===== verilog/pcx_cfg.svh
/*
 * Addresses, layout constants and timing figures for the counter array
 * PWM configuration block.
 * Assumes an 8-bit special function register bus with byte addresses.
 */
`ifndef PCX_CFG_SVH
`define PCX_CFG_SVH

// ******************************************************************
// Register addresses
// ******************************************************************
`define PCX_ADDR_PWM_CFG   8'hf7
`define PCX_ADDR_CLR_CTRL  8'h9c
`define PCX_ADDR_MODE0     8'hda
`define PCX_ADDR_MODE1     8'hdb
`define PCX_ADDR_MODE2     8'hdc
`define PCX_ADDR_CMP0_LO   8'hfb
`define PCX_ADDR_CMP0_HI   8'hfc
`define PCX_ADDR_CMP1_LO   8'he9
`define PCX_ADDR_CMP1_HI   8'hea
`define PCX_ADDR_CMP2_LO   8'heb
`define PCX_ADDR_CMP2_HI   8'hec

// ******************************************************************
// Values
// ******************************************************************
`define PCX_READ_UNMAPPED  8'h00
`define PCX_LEN_8          3'h0
`define PCX_LEN_9          3'h1
`define PCX_LEN_10         3'h2
`define PCX_LEN_11         3'h3
`define PCX_MASK_8         16'h00ff
`define PCX_MASK_9         16'h01ff
`define PCX_MASK_10        16'h03ff
`define PCX_MASK_11        16'h07ff
`define PCX_MASK_16        16'hffff

`endif

// ===== verilog/pcx_pkg.sv
/*
 * Types shared by the counter array PWM configuration block.
 * Assumes pcx_cfg.svh is on the include path.
 */
`include "pcx_cfg.svh"

package pcx_pkg;

    typedef logic [7:0]  pcx_byte_t;
    typedef logic [15:0] pcx_word_t;

    // PWM configuration register layout
    typedef struct packed {
        logic       reload_bank_select;
        logic       cycle_ovf_irq_enable;
        logic       cycle_ovf_flag;
        logic [1:0] rsvd;
        logic [2:0] cycle_length_select;
    } pcx_pwm_cfg_t;

    // Comparator clear control register layout
    typedef struct packed {
        logic       cmp_clear_polarity;
        logic [3:0] rsvd;
        logic       cmp_clear_enable_ch2;
        logic       cmp_clear_enable_ch1;
        logic       cmp_clear_enable_ch0;
    } pcx_clr_t;

    // Channel mode register layout
    typedef struct packed {
        logic wide_pwm_select;
        logic compare_enable;
        logic rising_capture_enable;
        logic falling_capture_enable;
        logic match_enable;
        logic toggle_enable;
        logic pwm_enable;
        logic cc_flag_irq_enable;
    } pcx_mode_t;

    // Counter wrap mask for a cycle length code; reserved codes act as 8
    function automatic pcx_word_t pcx_len_mask(input logic [2:0] cls);
        case (cls)
            `PCX_LEN_9:  pcx_len_mask = `PCX_MASK_9;
            `PCX_LEN_10: pcx_len_mask = `PCX_MASK_10;
            `PCX_LEN_11: pcx_len_mask = `PCX_MASK_11;
            default:     pcx_len_mask = `PCX_MASK_8;
        endcase
    endfunction

    // True for the 9 to 11 bit lengths that use the reload bank
    function automatic logic pcx_len_ext(input logic [2:0] cls);
        pcx_len_ext = (cls == `PCX_LEN_9) || (cls == `PCX_LEN_10) ||
                      (cls == `PCX_LEN_11);
    endfunction

endpackage

// ===== verilog/pcx_channel.sv
/*
 * One PWM channel output stage with comparator kill latch.
 * Assumes counter, compare value and events arrive on clk.
 */
`timescale 1ns/100ps
`include "pcx_cfg.svh"

module pcx_channel (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              arst_n,
    // Configuration
    input  wire pcx_pkg::pcx_mode_t mode,
    input  wire pcx_pkg::pcx_word_t cmp_value,
    input  wire pcx_pkg::pcx_word_t len_mask,
    // Timebase
    input  wire pcx_pkg::pcx_word_t cnt,
    input  wire logic              wrap_short,
    input  wire logic              wrap_wide,
    // Comparator clear
    input  wire logic              clear_evt,
    // Output
    output logic                   ch_out
);
    import pcx_pkg::*;

    typedef struct packed {
        logic out;
        logic killed;
    } pcx_ch_state_t;

    pcx_ch_state_t st_r;
    pcx_ch_state_t st_nxt;
    pcx_word_t     m;
    logic          restart;
    logic          below;

    // ******************************************************************
    // Waveform
    // ******************************************************************
    always_comb begin
        st_nxt  = st_r;
        m       = mode.wide_pwm_select ? `PCX_MASK_16 : len_mask;
        restart = mode.wide_pwm_select ? wrap_wide : wrap_short;
        below   = (cnt & m) < (cmp_value & m);
        // Kill holds until the channel's own cycle restarts
        if (clear_evt) begin
            st_nxt.killed = 1'b1;
        end else if (restart) begin
            st_nxt.killed = 1'b0;
        end
        st_nxt.out = mode.pwm_enable && !st_nxt.killed && below;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign ch_out = st_r.out;

    // ******************************************************************
    // Checks
    // ******************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    property p_kill;
        clear_evt |=> !ch_out;
    endproperty
    a_kill: assert property (p_kill)
        else $error("output not forced low by comparator clear");

    property p_off;
        !mode.pwm_enable |=> !ch_out;
    endproperty
    a_off: assert property (p_off)
        else $error("output active with PWM disabled");

endmodule

// ===== testbench/pcx_cpu_model.sv
/*
 * Bus master model of the CPU core for the PWM configuration block.
 * Assumes its tasks are called one at a time from a bench process.
 */
`timescale 1ns/100ps
`include "pcx_cfg.svh"

module pcx_cpu_model (
    // Clock
    input  wire logic               clk,
    // Register bus
    output pcx_pkg::pcx_byte_t      sfr_addr,
    output logic                    sfr_wr,
    output logic                    sfr_rd,
    output pcx_pkg::pcx_byte_t      sfr_wdata,
    input  wire pcx_pkg::pcx_byte_t sfr_rdata,
    input  wire logic               sfr_rvalid
);
    import pcx_pkg::*;

    initial begin
        sfr_addr  = 8'h00;
        sfr_wr    = 1'b0;
        sfr_rd    = 1'b0;
        sfr_wdata = 8'h00;
    end

    // One-cycle write; released data shows the inverse
    task automatic wr(input pcx_byte_t a, input pcx_byte_t d);
        pcx_byte_t m;
        m = d;
        if (a == `PCX_ADDR_PWM_CFG)
            m = d & 8'he7;
        if (a == `PCX_ADDR_CLR_CTRL)
            m = d & 8'h87;
        @(negedge clk);
        sfr_addr  = a;
        sfr_wdata = m;
        sfr_wr    = 1'b1;
        @(negedge clk);
        sfr_wr    = 1'b0;
        sfr_wdata = ~m;
    endtask

    // One-cycle read; answer taken in the following cycle
    task automatic rd(input pcx_byte_t a, output pcx_byte_t d,
                      output logic ok);
        @(negedge clk);
        sfr_addr = a;
        sfr_rd   = 1'b1;
        @(negedge clk);
        sfr_rd   = 1'b0;
        sfr_addr = ~a;
        ok       = sfr_rvalid;
        d        = sfr_rdata;
    endtask
endmodule

// ===== testbench/pca_pwm_cycle_and_comparator_clear_bench.sv
/*
 * Self-checking bench for the counter array PWM configuration block.
 * Assumes pcx_pkg and pcx_cfg.svh are compiled and on the include path.
 */
`timescale 1ns/100ps
`include "pcx_cfg.svh"

module pca_pwm_cycle_and_comparator_clear_bench;
    import pcx_pkg::*;

    logic      clk = 1'b0;
    logic      arst_n = 1'b0;
    pcx_byte_t sfr_addr, sfr_wdata, sfr_rdata;
    logic      sfr_wr, sfr_rd, sfr_rvalid, irq, o0, o1, o2;
    pcx_word_t cnt = 16'h0000;
    logic      tick = 1'b0;
    logic      cmp_in = 1'b1;
    int        n_errors = 0;
    int        checks = 0;

    pcx_cpu_model pcx_cpu_model_inst (.clk(clk), .sfr_addr(sfr_addr),
        .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
        .sfr_rdata(sfr_rdata), .sfr_rvalid(sfr_rvalid));

    pcx_top pcx_top_inst (.clk(clk), .arst_n(arst_n),
        .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
        .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .sfr_rvalid(sfr_rvalid), .main_array_counter(cnt),
        .cnt_tick(tick), .cmp_result_in(cmp_in), .pca_irq_req(irq),
        .channel_out_0(o0), .channel_out_1(o1), .channel_out_2(o2));

    initial begin
        forever #4 clk = ~clk;
    end

    // ******************************************************************
    // Helpers
    // ******************************************************************
    task automatic chk(input string n, input logic [15:0] e,
                       input logic [15:0] g);
        checks++;
        if (g !== e) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic w(input pcx_byte_t a, input pcx_byte_t d);
        pcx_cpu_model_inst.wr(a, d);
    endtask

    task automatic rchk(input pcx_byte_t a, input pcx_byte_t e);
        pcx_byte_t d;
        logic      ok;
        pcx_cpu_model_inst.rd(a, d, ok);
        chk("rvalid", 16'h0001, {15'h0000, ok});
        chk("rdata", {8'h00, e}, {8'h00, d});
    endtask

    task automatic tk(input pcx_word_t v);
        @(negedge clk);
        cnt  = v;
        tick = 1'b1;
        @(negedge clk);
        tick = 1'b0;
    endtask

    task automatic setcnt(input pcx_word_t v);
        @(negedge clk);
        cnt = v;
        @(negedge clk);
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // ******************************************************************
    // Scenarios
    // ******************************************************************
    task automatic t_reset;
        rchk(`PCX_ADDR_PWM_CFG, 8'h00);
        rchk(`PCX_ADDR_CLR_CTRL, 8'h00);
        rchk(`PCX_ADDR_MODE0, 8'h00);
        rchk(`PCX_ADDR_MODE1, 8'h00);
        rchk(`PCX_ADDR_MODE2, 8'h00);
        rchk(8'h01, 8'h00);
        $display("reset values done");
    endtask

    task automatic t_regs;
        w(`PCX_ADDR_MODE0, 8'hff);
        w(`PCX_ADDR_MODE1, 8'ha5);
        w(`PCX_ADDR_MODE2, 8'h5a);
        rchk(`PCX_ADDR_MODE0, 8'hff);
        rchk(`PCX_ADDR_MODE1, 8'ha5);
        rchk(`PCX_ADDR_MODE2, 8'h5a);
        w(`PCX_ADDR_CLR_CTRL, 8'hff);
        rchk(`PCX_ADDR_CLR_CTRL, 8'h87);
        w(`PCX_ADDR_CLR_CTRL, 8'h00);
        $display("register access done");
    endtask

    task automatic t_ovf;
        pcx_word_t m;
        for (int l = 0; l < 4; l++) begin
            m = (16'h0100 << l) - 16'h0001;
            w(`PCX_ADDR_PWM_CFG, 8'(l));
            tk(m >> 1);
            rchk(`PCX_ADDR_PWM_CFG, 8'(l));
            tk(m);
            rchk(`PCX_ADDR_PWM_CFG, 8'h20 | 8'(l));
            chk("irq", 16'h0000, {15'h0000, irq});
            w(`PCX_ADDR_PWM_CFG, 8'h60 | 8'(l));
            chk("irq", 16'h0001, {15'h0000, irq});
            w(`PCX_ADDR_PWM_CFG, 8'(l));
            rchk(`PCX_ADDR_PWM_CFG, 8'(l));
        end
        w(`PCX_ADDR_PWM_CFG, 8'h04);
        tk(16'h00ff);
        rchk(`PCX_ADDR_PWM_CFG, 8'h24);
        w(`PCX_ADDR_PWM_CFG, 8'h20);
        rchk(`PCX_ADDR_PWM_CFG, 8'h20);
        w(`PCX_ADDR_PWM_CFG, 8'h00);
        $display("cycle overflow done");
    endtask

    task automatic t_bank;
        w(`PCX_ADDR_CMP0_LO, 8'h11);
        w(`PCX_ADDR_PWM_CFG, 8'h80);
        w(`PCX_ADDR_CMP0_LO, 8'h22);
        rchk(`PCX_ADDR_CMP0_LO, 8'h22);
        w(`PCX_ADDR_PWM_CFG, 8'h00);
        rchk(`PCX_ADDR_CMP0_LO, 8'h11);
        $display("reload bank done");
    endtask

    task automatic t_pwm;
        w(`PCX_ADDR_MODE0, 8'h42);
        w(`PCX_ADDR_CMP0_LO, 8'h80);
        w(`PCX_ADDR_CMP0_HI, 8'h00);
        setcnt(16'h0010);
        chk("out0", 16'h0001, {15'h0000, o0});
        setcnt(16'h0090);
        chk("out0", 16'h0000, {15'h0000, o0});
        w(`PCX_ADDR_PWM_CFG, 8'h03);
        w(`PCX_ADDR_MODE0, 8'hc2);
        w(`PCX_ADDR_CMP0_LO, 8'h00);
        w(`PCX_ADDR_CMP0_HI, 8'h10);
        setcnt(16'h0800);
        chk("out0", 16'h0001, {15'h0000, o0});
        $display("pwm output done");
    endtask

    task automatic t_reload;
        w(`PCX_ADDR_MODE0, 8'h42);
        w(`PCX_ADDR_PWM_CFG, 8'h02);
        w(`PCX_ADDR_CMP0_LO, 8'h10);
        w(`PCX_ADDR_CMP0_HI, 8'h00);
        w(`PCX_ADDR_PWM_CFG, 8'h82);
        w(`PCX_ADDR_CMP0_LO, 8'h00);
        w(`PCX_ADDR_CMP0_HI, 8'h01);
        w(`PCX_ADDR_PWM_CFG, 8'h02);
        setcnt(16'h0080);
        chk("out0", 16'h0000, {15'h0000, o0});
        tk(16'h03ff);
        setcnt(16'h0080);
        chk("out0", 16'h0001, {15'h0000, o0});
        w(`PCX_ADDR_PWM_CFG, 8'h00);
        w(`PCX_ADDR_CMP0_LO, 8'h10);
        w(`PCX_ADDR_CMP0_HI, 8'h00);
        tk(16'h00ff);
        setcnt(16'h0008);
        chk("out0", 16'h0001, {15'h0000, o0});
        $display("auto reload done");
    endtask

    task automatic t_clear;
        w(`PCX_ADDR_MODE1, 8'h42);
        w(`PCX_ADDR_MODE2, 8'h42);
        w(`PCX_ADDR_CMP0_LO, 8'h80);
        w(`PCX_ADDR_CMP1_LO, 8'h80);
        w(`PCX_ADDR_CMP1_HI, 8'h00);
        w(`PCX_ADDR_CMP2_LO, 8'h80);
        w(`PCX_ADDR_CMP2_HI, 8'h00);
        w(`PCX_ADDR_CLR_CTRL, 8'h01);
        setcnt(16'h0010);
        @(negedge clk);
        cmp_in = 1'b0;
        repeat (3) @(negedge clk);
        chk("out0", 16'h0000, {15'h0000, o0});
        chk("out1", 16'h0001, {15'h0000, o1});
        tk(16'h00ff);
        setcnt(16'h0010);
        chk("out0", 16'h0001, {15'h0000, o0});
        w(`PCX_ADDR_CLR_CTRL, 8'h86);
        @(negedge clk);
        cmp_in = 1'b1;
        repeat (3) @(negedge clk);
        chk("out0", 16'h0001, {15'h0000, o0});
        chk("out1", 16'h0000, {15'h0000, o1});
        chk("out2", 16'h0000, {15'h0000, o2});
        $display("comparator clear done");
    endtask

    // ******************************************************************
    // Main sequence and watchdog
    // ******************************************************************
    initial begin
        repeat (6) @(posedge clk);
        @(negedge clk);
        arst_n = 1'b1;
        t_reset();
        t_regs();
        t_ovf();
        t_bank();
        t_pwm();
        t_reload();
        t_clear();
        wrap_up();
    end

    initial begin
        #40000;
        n_errors++;
        wrap_up();
    end
endmodule
